// File: inc/fcl_pkg.sv
// shared constants for the fault current limit configuration block
package fcl_pkg;
    // register byte offsets
    localparam logic [7:0] FCL_OFF_CFG = 8'h90;
    localparam logic [7:0] FCL_OFF_STS = 8'ha0;
    localparam logic [7:0] FCL_OFF_MASK = 8'ha4;
    localparam logic [7:0] FCL_OFF_CTRL = 8'ha8;
    localparam logic [7:0] FCL_OFF_LOCK = 8'hac;
    // reset values
    localparam logic [31:0] FCL_CFG_RST = 32'h00000000;
    localparam logic [2:0] FCL_STS_RST = 3'h0;
    localparam logic [2:0] FCL_MASK_RST = 3'h0;
    localparam logic [2:0] FCL_LIMIT_RST = 3'h3;
    // writable bits of the configuration word, bit 31 held at zero
    localparam logic [31:0] FCL_CFG_WMASK = 32'h7fffffff;
    // field positions (lsb) of the configuration word
    localparam int FCL_TORQUE_LSB = 27;
    localparam int FCL_CMP_LSB = 23;
    localparam int FCL_ADC_LSB = 19;
    localparam int FCL_MODE_LSB = 15;
    localparam int FCL_RETRY_LSB = 7;
    // control word fields
    localparam int FCL_CTRL_LIMIT_LSB = 0;
    localparam int FCL_CTRL_CLEAR_BIT = 8;
    // status event bits
    localparam int FCL_EV_ADC = 0;
    localparam int FCL_EV_CMP = 1;
    localparam int FCL_EV_LATCH = 2;
    // lock response codes
    localparam logic [3:0] FCL_MODE_RETRY_MIN = 4'h4;
    localparam logic [3:0] FCL_MODE_REPORT = 4'h8;
    localparam logic [3:0] FCL_MODE_OFF_MIN = 4'h9;
    // current steps in units of 1/128 A
    localparam logic [9:0] FCL_CUR_BASE = 10'h00a;
    localparam logic [9:0] FCL_CUR_STEP = 10'h028;
    localparam logic [9:0] FCL_CUR_E = 10'h230;
    localparam logic [9:0] FCL_CUR_F = 10'h280;
    // retry interval step per code
    localparam int FCL_RETRY_STEP_MS = 100;
    localparam int FCL_CLK_KHZ = 10000;
    localparam int FCL_RETRY_STEP_CYC = FCL_RETRY_STEP_MS * FCL_CLK_KHZ;
    // axi responses
    localparam logic [1:0] FCL_RESP_OKAY = 2'h0;
    localparam logic [1:0] FCL_RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {FCL_LK_IDLE, FCL_LK_REPORT, FCL_LK_RETRY, FCL_LK_LATCHED} fcl_lk_t;
endpackage

// File: rtl/fcl_current_decode.sv
// decoder from a 4-bit current code to 1/128 A units
`timescale 1ns/1ns
module fcl_current_decode (
    input wire logic [3:0] code,
    output logic [9:0] current
);
    import fcl_pkg::*;
    always_comb begin
        case (code)
            4'h0: current = FCL_CUR_BASE;
            4'h1: current = 10'(FCL_CUR_BASE << 1);
            4'h2: current = 10'(FCL_CUR_BASE << 2);
            4'he: current = FCL_CUR_E;
            4'hf: current = FCL_CUR_F;
            default: current = 10'(FCL_CUR_STEP * 10'(code - 4'h1));
        endcase
    end
endmodule

// File: rtl/fcl_fault_config.sv
// fault current limit configuration register with lock response and axi4-lite slave
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns
module fcl_fault_config #(
    parameter int ADDR_W = 8,
    parameter int RETRY_STEP_CYCLES = fcl_pkg::FCL_RETRY_STEP_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [9:0] adc_current,
    input wire logic adc_valid,
    input wire logic comp_lock_trip,
    output logic [9:0] torque_current_ref,
    output logic [9:0] comparator_lock_threshold,
    output logic fault_out_n,
    output logic gate_tristate,
    output logic brake_high,
    output logic brake_low,
    output logic irq
);
    import fcl_pkg::*;

    // refuse sizes that the decode and the retry timer cannot hold
    if (ADDR_W < 8 || RETRY_STEP_CYCLES < 1
        || RETRY_STEP_CYCLES > 32'h0fffffff) begin : g_param_check
        $error("fcl_fault_config: unsupported parameter values");
    end

    // register state
    logic [31:0] fault_config_one, next_fault_config_one;
    logic [2:0] irq_status, next_irq_status;
    logic [2:0] irq_mask, next_irq_mask;
    logic [2:0] retry_limit_count, next_retry_limit_count;
    logic next_irq;
    // bus state
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [ADDR_W-1:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    // lock state
    fcl_lk_t lk_state, next_lk_state;
    logic [1:0] lk_action, next_lk_action;
    logic [2:0] retry_done, next_retry_done;
    logic [31:0] retry_timer, next_retry_timer;
    logic next_fault_out_n, next_gate_tristate, next_brake_high, next_brake_low;
    // pin synchroniser
    logic trip_s1, trip_s2, trip_s3, trip_stable, next_trip_stable;
    // decoded currents
    logic [9:0] dec_cur [3];
    logic [9:0] adc_limit;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_dec
            fcl_current_decode u_dec (
                .code(fault_config_one[FCL_TORQUE_LSB - 4*gi +: 4]),
                .current(dec_cur[gi])
            );
        end
    endgenerate
    // adc threshold taken from bits 22-19
    assign adc_limit = dec_cur[2];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a);
        logic [7:0] o;
        o = a[7:0];
        return ((a >> 8) == '0) && (o == FCL_OFF_CFG || o == FCL_OFF_STS ||
               o == FCL_OFF_MASK || o == FCL_OFF_CTRL || o == FCL_OFF_LOCK);
    endfunction

    // write becomes effective once address and data are both held
    logic do_write, wr_cfg, wr_sts, wr_mask, wr_ctrl, clear_req;
    logic [31:0] wr_merged;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_cfg = do_write && hit(aw_addr) && aw_addr[7:0] == FCL_OFF_CFG;
    assign wr_sts = do_write && hit(aw_addr) && aw_addr[7:0] == FCL_OFF_STS;
    assign wr_mask = do_write && hit(aw_addr) && aw_addr[7:0] == FCL_OFF_MASK;
    assign wr_ctrl = do_write && hit(aw_addr) && aw_addr[7:0] == FCL_OFF_CTRL;
    assign wr_merged = merge(32'h0, w_data, w_strb);
    assign clear_req = wr_ctrl && wr_merged[FCL_CTRL_CLEAR_BIT];

    // bus channels
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = hit(aw_addr) ? FCL_RESP_OKAY : FCL_RESP_SLVERR;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = hit(s_axi_araddr) ? FCL_RESP_OKAY : FCL_RESP_SLVERR;
            // unmapped reads return zero with slverr
            case (s_axi_araddr[7:0])
                FCL_OFF_CFG: next_rdata = fault_config_one;
                FCL_OFF_STS: next_rdata = {29'h0, irq_status};
                FCL_OFF_MASK: next_rdata = {29'h0, irq_mask};
                FCL_OFF_CTRL: next_rdata = {29'h0, retry_limit_count};
                FCL_OFF_LOCK: next_rdata = {24'h0, trip_stable, retry_done, 2'h0, lk_state};
                default: next_rdata = 32'h0;
            endcase
            if (!hit(s_axi_araddr)) begin
                next_rdata = 32'h0;
            end
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= FCL_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= FCL_RESP_OKAY;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // trip pin: only the agreeing later stages are looked at
    always_comb begin
        next_trip_stable = (trip_s2 == trip_s3) ? trip_s2 : trip_stable;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            trip_s1 <= 1'b0;
            trip_s2 <= 1'b0;
            trip_s3 <= 1'b0;
            trip_stable <= 1'b0;
        end else begin
            trip_s1 <= comp_lock_trip;
            trip_s2 <= trip_s1;
            trip_s3 <= trip_s2;
            trip_stable <= next_trip_stable;
        end
    end

    // lock detection and response
    logic [3:0] lk_mode;
    logic adc_over, ev_adc, ev_cmp, ev_latch;
    assign lk_mode = fault_config_one[FCL_MODE_LSB +: 4];
    // codes 9h and above disable detection
    assign adc_over = adc_valid && adc_current > adc_limit && lk_mode < FCL_MODE_OFF_MIN;
    assign ev_adc = adc_over && lk_state == FCL_LK_IDLE;
    assign ev_cmp = next_trip_stable && !trip_stable;
    assign ev_latch = next_lk_state == FCL_LK_LATCHED && lk_state != FCL_LK_LATCHED;

    always_comb begin
        next_lk_state = lk_state;
        next_lk_action = lk_action;
        next_retry_done = retry_done;
        next_retry_timer = retry_timer;
        case (lk_state)
            FCL_LK_IDLE: begin
                if (adc_over) begin
                    next_lk_action = lk_mode[1:0];
                    // report only, latch, or timed retry
                    if (lk_mode == FCL_MODE_REPORT) begin
                        next_lk_state = FCL_LK_REPORT;
                    end else if (lk_mode < FCL_MODE_RETRY_MIN) begin
                        next_lk_state = FCL_LK_LATCHED;
                    end else if (retry_done >= retry_limit_count) begin
                        next_lk_state = FCL_LK_LATCHED;
                    end else begin
                        next_lk_state = FCL_LK_RETRY;
                        next_retry_timer = 32'(({28'h0, fault_config_one[FCL_RETRY_LSB +: 4]}
                                           + 32'h1) * 32'(RETRY_STEP_CYCLES));
                    end
                end
            end
            FCL_LK_RETRY: begin
                // automatic clear after the retry interval
                if (retry_timer <= 32'h1) begin
                    next_lk_state = FCL_LK_IDLE;
                    next_retry_done = retry_done + 3'h1;
                end else begin
                    next_retry_timer = retry_timer - 32'h1;
                end
            end
            FCL_LK_REPORT, FCL_LK_LATCHED: begin
                // latched faults leave only by software clear
                if (clear_req) begin
                    next_lk_state = FCL_LK_IDLE;
                    next_retry_done = 3'h0;
                end
            end
            default: next_lk_state = FCL_LK_IDLE;
        endcase
        if (clear_req && lk_state == FCL_LK_IDLE) begin
            next_retry_done = 3'h0;
        end
        next_fault_out_n = next_lk_state == FCL_LK_IDLE;
        next_gate_tristate = 1'b0;
        next_brake_high = 1'b0;
        next_brake_low = 1'b0;
        if (next_lk_state == FCL_LK_RETRY || next_lk_state == FCL_LK_LATCHED) begin
            next_gate_tristate = !next_lk_action[1];
            next_brake_high = next_lk_action == 2'h2;
            next_brake_low = next_lk_action == 2'h3;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lk_state <= FCL_LK_IDLE;
            lk_action <= 2'h0;
            retry_done <= 3'h0;
            retry_timer <= 32'h0;
            fault_out_n <= 1'b1;
            gate_tristate <= 1'b0;
            brake_high <= 1'b0;
            brake_low <= 1'b0;
        end else begin
            lk_state <= next_lk_state;
            lk_action <= next_lk_action;
            retry_done <= next_retry_done;
            retry_timer <= next_retry_timer;
            fault_out_n <= next_fault_out_n;
            gate_tristate <= next_gate_tristate;
            brake_high <= next_brake_high;
            brake_low <= next_brake_low;
        end
    end

    // configuration, interrupt status and mask
    always_comb begin
        next_fault_config_one = fault_config_one;
        next_irq_mask = irq_mask;
        next_retry_limit_count = retry_limit_count;
        next_irq_status = irq_status;
        if (wr_cfg) begin
            next_fault_config_one = merge(fault_config_one, w_data, w_strb) & FCL_CFG_WMASK;
        end
        // both fields sit in byte 0, so only its strobe matters
        if (wr_mask && w_strb[0]) begin
            next_irq_mask = w_data[2:0];
        end
        if (wr_ctrl && w_strb[0]) begin
            next_retry_limit_count = w_data[FCL_CTRL_LIMIT_LSB +: 3];
        end
        // a new event outweighs a clear in the same cycle
        if (wr_sts) begin
            next_irq_status = irq_status & ~wr_merged[2:0];
        end
        next_irq_status[FCL_EV_ADC] = next_irq_status[FCL_EV_ADC] | ev_adc;
        next_irq_status[FCL_EV_CMP] = next_irq_status[FCL_EV_CMP] | ev_cmp;
        next_irq_status[FCL_EV_LATCH] = next_irq_status[FCL_EV_LATCH] | ev_latch;
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fault_config_one <= FCL_CFG_RST;
            irq_status <= FCL_STS_RST;
            irq_mask <= FCL_MASK_RST;
            retry_limit_count <= FCL_LIMIT_RST;
            irq <= 1'b0;
            torque_current_ref <= 10'h0;
            comparator_lock_threshold <= 10'h0;
        end else begin
            fault_config_one <= next_fault_config_one;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            retry_limit_count <= next_retry_limit_count;
            irq <= next_irq;
            torque_current_ref <= dec_cur[0];
            comparator_lock_threshold <= dec_cur[1];
        end
    end
endmodule

// File: testbench/fcl_fault_config_sva.sv
// checker for the fault current limit configuration block
`timescale 1ns/1ns
module fcl_fault_config_sva
    import fcl_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int RETRY_STEP_CYCLES = FCL_RETRY_STEP_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [9:0] torque_current_ref,
    input wire logic [9:0] comparator_lock_threshold,
    input wire logic fault_out_n,
    input wire logic gate_tristate,
    input wire logic brake_high,
    input wire logic brake_low
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    AST_RD_ANSWER: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    AST_RD_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
        && $stable(s_axi_rresp)) else $error("read data not held");
    AST_RD_SLVERR: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
        |=> s_axi_rresp == FCL_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read ok");
    AST_WR_ANSWER: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    AST_WR_HOLD: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    AST_RST_VALUE: assert property (
        $rose(reset_n) |-> ##1 torque_current_ref == 10'h00a
        && comparator_lock_threshold == 10'h00a) else $error("reset currents wrong");
    AST_TORQUE_LEGAL: assert property (
        $past(reset_n) |-> torque_current_ref inside {10'h00a, 10'h014, 10'h028, 10'h050,
        10'h078, 10'h0a0, 10'h0c8, 10'h0f0, 10'h118, 10'h140, 10'h168, 10'h190, 10'h1b8,
        10'h1e0, 10'h230, 10'h280}) else $error("torque reference off table");
    AST_CMP_LEGAL: assert property (
        $past(reset_n) |-> comparator_lock_threshold inside {10'h00a, 10'h014, 10'h028,
        10'h050, 10'h078, 10'h0a0, 10'h0c8, 10'h0f0, 10'h118, 10'h140, 10'h168, 10'h190,
        10'h1b8, 10'h1e0, 10'h230, 10'h280}) else $error("comparator limit off table");
    AST_RD_BIT31: assert property (
        s_axi_rvalid |-> !s_axi_rdata[31]) else $error("reserved bit read as one");
    AST_GATE_FAULT: assert property (
        gate_tristate || brake_high || brake_low |-> !fault_out_n
        && $onehot0({gate_tristate, brake_high, brake_low})) else $error("gate action wrong");
endmodule

bind fcl_fault_config fcl_fault_config_sva #(
    .ADDR_W(ADDR_W),
    .RETRY_STEP_CYCLES(RETRY_STEP_CYCLES)
) chk_u (.mclk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .torque_current_ref,
    .comparator_lock_threshold, .fault_out_n, .gate_tristate, .brake_high, .brake_low);

// File: testbench/tb_top.sv
// self-checking bench for the fault current limit configuration block
`timescale 1ns/1ns
module tb_top;
    import fcl_pkg::*;
    // short retry step keeps the retry wait to a few cycles
    localparam int STEP = 4;
    logic mclk, reset_n;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, cfg_m, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [9:0] adc_current, torque_current_ref, comparator_lock_threshold;
    logic adc_valid, comp_lock_trip, fault_out_n, gate_tristate, brake_high, brake_low, irq;
    int err_total, check_count, seed;
    int modes[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 12, 15};

    fcl_fault_config #(.ADDR_W(8), .RETRY_STEP_CYCLES(STEP)) dut_u (.mclk, .reset_n,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .adc_current, .adc_valid, .comp_lock_trip,
        .torque_current_ref, .comparator_lock_threshold, .fault_out_n, .gate_tristate,
        .brake_high, .brake_low, .irq);

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic print_verdict;
        $display("mismatches %0d of %0d checks", err_total, check_count);
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // current code to 1/128 A units
    function automatic logic [9:0] dec(input logic [3:0] c);
        if (c < 4'h4) return 10'h00a << c;
        if (c < 4'he) return 10'h050 + 10'h028 * (c - 4'h3);
        return (c == 4'he) ? 10'h230 : 10'h280;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        logic aw, w;
        logic [31:0] bm;
        aw = 1'b0;
        w = 1'b0;
        bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge mclk);
            if (!aw && s_axi_awready) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
        // bit 31 never stored
        if (a == 8'h90 && er == FCL_RESP_OKAY) cfg_m = (cfg_m & ~bm) | (d & bm & 32'h7fffffff);
    endtask

    task automatic rdr(input logic [7:0] a, input logic [1:0] er);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        chk(s_axi_rresp, er);
    endtask

    task automatic adc(input logic [9:0] v);
        @(posedge mclk);
        adc_current <= v;
        adc_valid <= 1'b1;
        @(posedge mclk);
        adc_valid <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    task automatic lc(input int mode, input int lim);
        logic act, lat;
        logic [2:0] g;
        act = mode < 9;
        lat = mode < 4 || (mode < 8 && lim == 0);
        g = (mode[1:0] < 2) ? 3'h4 : (mode[1:0] == 2) ? 3'h2 : 3'h1;
        wr(FCL_OFF_CTRL, 32'h100 | lim, 4'hf, FCL_RESP_OKAY);
        wr(FCL_OFF_STS, 32'h7, 4'hf, FCL_RESP_OKAY);
        wr(FCL_OFF_CFG, (32'h5 << 27) | (32'h2 << 23) | (32'h3 << 19) | (mode << 15)
            | (32'h3 << 7), 4'hf, FCL_RESP_OKAY);
        adc(10'h050);
        chk(fault_out_n, 1'b1);
        adc(10'h051);
        chk(fault_out_n, !act);
        chk({gate_tristate, brake_high, brake_low}, (mode < 8) ? g : 3'h0);
        rdr(FCL_OFF_STS, FCL_RESP_OKAY);
        chk(rd, {lat, 1'b0, act});
        chk(irq, act);
        if (act && !lat && mode > 3) begin
            repeat (24) @(posedge mclk);
            // report only never clears by itself
            chk(fault_out_n, mode != 8);
            rdr(FCL_OFF_LOCK, FCL_RESP_OKAY);
            chk(rd[6:4], (mode == 8) ? 3'h0 : 3'h1);
        end
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        print_verdict;
    end

    initial begin
        logic [31:0] d;
        logic [3:0] s;
        seed = 44;
        err_total = 0;
        check_count = 0;
        cfg_m = 32'h0;
        reset_n = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {adc_current, adc_valid, comp_lock_trip} = '0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (2) @(posedge mclk);
        chk(torque_current_ref, 10'h00a);
        rdr(FCL_OFF_CFG, FCL_RESP_OKAY);
        chk(rd, 32'h0);
        rdr(FCL_OFF_CTRL, FCL_RESP_OKAY);
        chk(rd, 32'h3);
        // neighbour and unaligned places answer with an error
        rdr(8'h94, FCL_RESP_SLVERR);
        chk(rd, 32'h0);
        rdr(8'h92, FCL_RESP_SLVERR);
        wr(8'h91, 32'hffffffff, 4'hf, FCL_RESP_SLVERR);
        rdr(FCL_OFF_CFG, FCL_RESP_OKAY);
        chk(rd, 32'h0);
        // every code with random partial strobes; mode kept at disabled
        for (int c = 0; c < 16; c++) begin
            d = $random(seed);
            s = $random(seed);
            d[31] = 1'b1;
            d[30:27] = c[3:0];
            d[26:23] = 4'hf - c[3:0];
            d[18:15] = 4'hf;
            wr(FCL_OFF_CFG, d, s | 4'hc, FCL_RESP_OKAY);
            rdr(FCL_OFF_CFG, FCL_RESP_OKAY);
            chk(rd, cfg_m);
            chk(torque_current_ref, dec(cfg_m[30:27]));
            chk(comparator_lock_threshold, dec(cfg_m[26:23]));
        end
        wr(FCL_OFF_MASK, 32'h5, 4'hf, FCL_RESP_OKAY);
        foreach (modes[i]) lc(modes[i], 3);
        lc(5, 0);
        wr(FCL_OFF_CTRL, 32'h103, 4'hf, FCL_RESP_OKAY);
        wr(FCL_OFF_STS, 32'h7, 4'hf, FCL_RESP_OKAY);
        @(posedge mclk);
        comp_lock_trip <= 1'b1;
        repeat (8) @(posedge mclk);
        rdr(FCL_OFF_STS, FCL_RESP_OKAY);
        chk(rd, 32'h2);
        chk(irq, 1'b0);
        wr(FCL_OFF_MASK, 32'h7, 4'hf, FCL_RESP_OKAY);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b1);
        wr(FCL_OFF_STS, 32'h2, 4'hf, FCL_RESP_OKAY);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
        print_verdict;
    end
endmodule
